// [core/bml_pkg.sv]
// constants, types and register map of the boot mode select loader
//------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------
// Functional notes
// - three boot modes chosen by strap levels
// - strap select sampled as input after reset
// - eprom boot later drives pin as chip select
// - strap high: idle, wait for outside loader
// - eprom: channel 0 fetches 256 words, block 0
// - eprom done: execute from address zero
// - host: first auto-dma channel to send takes all 256 words
// - host done: execute from address zero
// - link: any receive link, 256 words, done event
// - link done: execute from address zero
// - both straps high: load nothing, wait interrupt
// - interrupt lines only if enable strap set
// - fixed default vectors per interrupt line
package bml_pkg;
   //------------------------------------------------------------------
   // sizes and timing
   //------------------------------------------------------------------
   localparam int           WORD_W          = 32;
   localparam int           ADDR_W          = 8;
   localparam int           CNT_W           = 9;
   localparam int           FIFO_DEPTH      = 8;
   localparam logic [8:0]   BOOT_WORDS      = 9'h100;
   localparam logic [8:0]   LAST_WORD       = 9'h0FF;
   localparam logic [7:0]   SAMPLE_CYCLES   = 8'h10;
   localparam logic [7:0]   CS_DELAY_CYCLES = 8'h08;
   //------------------------------------------------------------------
   // start vectors
   //------------------------------------------------------------------
   localparam logic [31:0]  BOOT_VECTOR     = 32'h0000_0000;
   localparam logic [31:0]  IRQ0_VECTOR     = 32'h0300_0000;
   localparam logic [31:0]  IRQ1_VECTOR     = 32'h3800_0000;
   localparam logic [31:0]  IRQ2_VECTOR     = 32'h0800_0000;
   localparam logic [31:0]  IRQ3_VECTOR     = 32'h0000_0000;
   //------------------------------------------------------------------
   // word source channels
   //------------------------------------------------------------------
   localparam logic [2:0]   CH_EPROM        = 3'h0;
   localparam logic [2:0]   CH_AUTO0        = 3'h1;
   localparam logic [2:0]   CH_AUTO1        = 3'h2;
   localparam logic [2:0]   CH_LINK0        = 3'h4;
   //------------------------------------------------------------------
   // register map
   //------------------------------------------------------------------
   localparam logic [11:0]  REG_CTRL        = 12'h000;
   localparam logic [11:0]  REG_STATUS      = 12'h004;
   localparam logic [11:0]  REG_COUNT       = 12'h008;
   localparam logic [11:0]  REG_VECTOR      = 12'h00C;
   localparam logic [3:0]   CTRL_MASK_RST   = 4'hF;
   localparam int           ST_STATE_LSB    = 0;
   localparam int           ST_MODE_LSB     = 5;
   localparam int           ST_CH_LSB       = 7;
   localparam int           ST_LOCK_BIT     = 10;
   localparam int           ST_SEL_BIT      = 11;
   localparam int           ST_BM_BIT       = 12;
   localparam int           ST_INTERRUPT_ENABLE_STRAP_BIT    = 13;
   localparam int           ST_RUN_BIT      = 14;
   //------------------------------------------------------------------
   // types
   //------------------------------------------------------------------
   typedef enum logic [4:0]
   {
      S_RESET_WAIT = 5'h01,
      S_CS_WAIT    = 5'h02,
      S_LOAD       = 5'h04,
      S_IRQ_WAIT   = 5'h08,
      S_RUN        = 5'h10
   } bml_state_type;
   typedef enum logic [1:0]
   {
      M_EPROM  = 2'h0,
      M_SLAVE  = 2'h1,
      M_NOBOOT = 2'h2
   } bml_mode_type;
endpackage

// [core/bml_fifo.sv]
// word fifo between boot sources and block 0 writes
`timescale 1ns/1ps
module bml_fifo
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW:0]      wr_q;
   logic [PW:0]      wr_d;
   logic [PW:0]      rd_q;
   logic [PW:0]      rd_d;
   logic             push;
   logic             pop;
   //------------------------------------------------------------------
   // pointers and flags
   //------------------------------------------------------------------
   assign in_ready  = !((wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]));
   assign out_valid = (wr_q != rd_q);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_q[rd_q[PW-1:0]];
   always_comb
   begin
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end
   //------------------------------------------------------------------
   // storage
   //------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_q[wr_q[PW-1:0]] <= in_data;
      end
   end
endmodule

// [core/bml_boot_mode_select_loader.sv]
// boot mode select loader: strap sampling, boot word loading, start
`timescale 1ns/1ps
module bml_boot_mode_select_loader
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire logic        boot_strap_select_i,
   output      logic        boot_strap_select_o,
   output      logic        boot_strap_select_oe,
   input  wire logic        boot_mode_strap,
   input  wire logic        interrupt_enable_strap,
   input  wire logic [3:0]  external_interrupt_lines_n,
   output      logic        eprom_rd_req,
   output      logic [7:0]  eprom_rd_addr,
   input  wire logic        word_in_valid,
   output      logic        word_in_ready,
   input  wire logic [2:0]  word_in_channel,
   input  wire logic [31:0] word_in_data,
   output      logic        mem_wr_en,
   input  wire logic        mem_wr_ready,
   output      logic [7:0]  mem_wr_addr,
   output      logic [31:0] mem_wr_data,
   output      logic        boot_dma_done,
   output      logic        core_start,
   output      logic        core_run,
   output      logic [31:0] core_start_vector
);
   //------------------------------------------------------------------
   // declarations
   //------------------------------------------------------------------
   bml_pkg::bml_state_type state_q;
   bml_pkg::bml_state_type state_d;
   bml_pkg::bml_mode_type  mode_q;
   bml_pkg::bml_mode_type  mode_d;
   logic [6:0]  sync1_q;
   logic [6:0]  sync2_q;
   logic [7:0]  cnt_q;
   logic [7:0]  cnt_d;
   logic        sel_smp_q;
   logic        sel_smp_d;
   logic        bm_smp_q;
   logic        bm_smp_d;
   logic        irq_en_q;
   logic        irq_en_d;
   logic        locked_q;
   logic        locked_d;
   logic [2:0]  lock_ch_q;
   logic [2:0]  lock_ch_d;
   logic [8:0]  fetch_q;
   logic [8:0]  fetch_d;
   logic [8:0]  in_cnt_q;
   logic [8:0]  in_cnt_d;
   logic [8:0]  wr_cnt_q;
   logic [8:0]  wr_cnt_d;
   logic        oe_q;
   logic        oe_d;
   logic        cs_n_q;
   logic        cs_n_d;
   logic        req_q;
   logic        req_d;
   logic        run_q;
   logic        run_d;
   logic        start_q;
   logic        start_d;
   logic        done_q;
   logic        done_d;
   logic [31:0] vec_q;
   logic [31:0] vec_d;
   logic [3:0]  mask_q;
   logic [3:0]  mask_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        sel_sync;
   logic        bm_sync;
   logic        interrupt_enable_strap_sync;
   logic [3:0]  irq_act;
   logic        ch_ok;
   logic        acc_ok;
   logic        take;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic        fifo_out_ready;
   logic [31:0] fifo_out_data;
   logic        mem_fire;
   logic        addr_ok;
   logic [31:0] status_word;
   //------------------------------------------------------------------
   // pin synchronisers
   //------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_q <= 7'h7F;
         sync2_q <= 7'h7F;
      end
      else
      begin
         sync1_q <= {external_interrupt_lines_n, interrupt_enable_strap,
                     boot_mode_strap, boot_strap_select_i};
         sync2_q <= sync1_q;
      end
   end
   assign sel_sync   = sync2_q[0];
   assign bm_sync    = sync2_q[1];
   assign interrupt_enable_strap_sync = sync2_q[2];
   assign irq_act    = ~sync2_q[6:3] & mask_q;
   //------------------------------------------------------------------
   // word acceptance
   //------------------------------------------------------------------
   always_comb
   begin
      ch_ok = 1'b0;
      if (mode_q == bml_pkg::M_EPROM)
      begin
         ch_ok = (word_in_channel == bml_pkg::CH_EPROM);
      end
      else if (mode_q == bml_pkg::M_SLAVE)
      begin
         ch_ok = (word_in_channel == bml_pkg::CH_AUTO0) ||
                 (word_in_channel == bml_pkg::CH_AUTO1) ||
                 (word_in_channel[2] == bml_pkg::CH_LINK0[2]);
         if (locked_q)
         begin
            ch_ok = (word_in_channel == lock_ch_q);
         end
      end
   end
   assign acc_ok         = (state_q == bml_pkg::S_LOAD) && (in_cnt_q < bml_pkg::BOOT_WORDS)
                           && ch_ok;
   assign word_in_ready  = acc_ok && fifo_in_ready;
   assign take           = word_in_valid && word_in_ready;
   assign fifo_out_ready = mem_wr_ready && (state_q == bml_pkg::S_LOAD);
   assign mem_wr_en      = fifo_out_valid && (state_q == bml_pkg::S_LOAD);
   assign mem_fire       = mem_wr_en && mem_wr_ready;
   bml_fifo
   #(
      .WIDTH (bml_pkg::WORD_W),
      .DEPTH (bml_pkg::FIFO_DEPTH)
   )
   u_fifo
   (
      .clk       (pclk),
      .rst_n     (presetn),
      .in_valid  (word_in_valid && acc_ok),
      .in_ready  (fifo_in_ready),
      .in_data   (word_in_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );
   //------------------------------------------------------------------
   // boot sequencer
   //------------------------------------------------------------------
   always_comb
   begin
      state_d   = state_q;
      mode_d    = mode_q;
      cnt_d     = cnt_q;
      sel_smp_d = sel_smp_q;
      bm_smp_d  = bm_smp_q;
      irq_en_d  = irq_en_q;
      locked_d  = locked_q;
      lock_ch_d = lock_ch_q;
      fetch_d   = fetch_q;
      in_cnt_d  = in_cnt_q;
      wr_cnt_d  = wr_cnt_q;
      oe_d      = oe_q;
      cs_n_d    = cs_n_q;
      run_d     = run_q;
      vec_d     = vec_q;
      start_d   = 1'b0;
      done_d    = 1'b0;
      unique case (state_q)
         bml_pkg::S_RESET_WAIT:
         begin
            if (cnt_q == 8'h00)
            begin
               sel_smp_d = sel_sync;
               bm_smp_d  = bm_sync;
               irq_en_d  = interrupt_enable_strap_sync;
               cnt_d     = bml_pkg::CS_DELAY_CYCLES - 8'h01;
               if (!sel_sync)
               begin
                  mode_d  = bml_pkg::M_EPROM;
                  state_d = bml_pkg::S_CS_WAIT;
               end
               else if (bm_sync)
               begin
                  mode_d  = bml_pkg::M_NOBOOT;
                  state_d = bml_pkg::S_IRQ_WAIT;
               end
               else
               begin
                  mode_d  = bml_pkg::M_SLAVE;
                  state_d = bml_pkg::S_LOAD;
               end
            end
            else
            begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         bml_pkg::S_CS_WAIT:
         begin
            if (cnt_q == 8'h00)
            begin
               oe_d    = 1'b1;
               cs_n_d  = 1'b0;
               state_d = bml_pkg::S_LOAD;
            end
            else
            begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         bml_pkg::S_LOAD:
         begin
            if (take)
            begin
               in_cnt_d = in_cnt_q + 9'h001;
               if (mode_q == bml_pkg::M_EPROM)
               begin
                  fetch_d = fetch_q + 9'h001;
               end
               if (!locked_q)
               begin
                  locked_d  = 1'b1;
                  lock_ch_d = word_in_channel;
               end
            end
            if (mem_fire)
            begin
               wr_cnt_d = wr_cnt_q + 9'h001;
               if (wr_cnt_q == bml_pkg::LAST_WORD)
               begin
                  done_d  = 1'b1;
                  start_d = 1'b1;
                  run_d   = 1'b1;
                  vec_d   = bml_pkg::BOOT_VECTOR;
                  cs_n_d  = 1'b1;
                  state_d = bml_pkg::S_RUN;
               end
            end
         end
         bml_pkg::S_IRQ_WAIT:
         begin
            if (irq_en_q && (irq_act != 4'h0))
            begin
               start_d = 1'b1;
               run_d   = 1'b1;
               state_d = bml_pkg::S_RUN;
               if (irq_act[0])
               begin
                  vec_d = bml_pkg::IRQ0_VECTOR;
               end
               else if (irq_act[1])
               begin
                  vec_d = bml_pkg::IRQ1_VECTOR;
               end
               else if (irq_act[2])
               begin
                  vec_d = bml_pkg::IRQ2_VECTOR;
               end
               else
               begin
                  vec_d = bml_pkg::IRQ3_VECTOR;
               end
            end
         end
         bml_pkg::S_RUN:
         begin
            state_d = bml_pkg::S_RUN;
         end
      endcase
      req_d = (state_d == bml_pkg::S_LOAD) && (mode_d == bml_pkg::M_EPROM) &&
              (fetch_d < bml_pkg::BOOT_WORDS);
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q   <= bml_pkg::S_RESET_WAIT;
         mode_q    <= bml_pkg::M_SLAVE;
         cnt_q     <= bml_pkg::SAMPLE_CYCLES - 8'h01;
         sel_smp_q <= 1'b1;
         bm_smp_q  <= 1'b0;
         irq_en_q  <= 1'b0;
         locked_q  <= 1'b0;
         lock_ch_q <= 3'h0;
         fetch_q   <= 9'h000;
         in_cnt_q  <= 9'h000;
         wr_cnt_q  <= 9'h000;
         oe_q      <= 1'b0;
         cs_n_q    <= 1'b1;
         req_q     <= 1'b0;
         run_q     <= 1'b0;
         start_q   <= 1'b0;
         done_q    <= 1'b0;
         vec_q     <= 32'h0000_0000;
      end
      else
      begin
         state_q   <= state_d;
         mode_q    <= mode_d;
         cnt_q     <= cnt_d;
         sel_smp_q <= sel_smp_d;
         bm_smp_q  <= bm_smp_d;
         irq_en_q  <= irq_en_d;
         locked_q  <= locked_d;
         lock_ch_q <= lock_ch_d;
         fetch_q   <= fetch_d;
         in_cnt_q  <= in_cnt_d;
         wr_cnt_q  <= wr_cnt_d;
         oe_q      <= oe_d;
         cs_n_q    <= cs_n_d;
         req_q     <= req_d;
         run_q     <= run_d;
         start_q   <= start_d;
         done_q    <= done_d;
         vec_q     <= vec_d;
      end
   end
   assign boot_strap_select_oe = oe_q;
   assign boot_strap_select_o  = cs_n_q;
   assign eprom_rd_req         = req_q;
   assign eprom_rd_addr        = fetch_q[7:0];
   assign mem_wr_addr          = wr_cnt_q[7:0];
   assign mem_wr_data          = fifo_out_data;
   assign boot_dma_done        = done_q;
   assign core_start           = start_q;
   assign core_run             = run_q;
   assign core_start_vector    = vec_q;
   //------------------------------------------------------------------
   // apb register slave
   //------------------------------------------------------------------
   assign addr_ok = (paddr == bml_pkg::REG_CTRL) || (paddr == bml_pkg::REG_STATUS) ||
                    (paddr == bml_pkg::REG_COUNT) || (paddr == bml_pkg::REG_VECTOR);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign prdata  = rdata_q;
   always_comb
   begin
      status_word                                   = 32'h0000_0000;
      status_word[bml_pkg::ST_STATE_LSB+:5]         = state_q;
      status_word[bml_pkg::ST_MODE_LSB+:2]          = mode_q;
      status_word[bml_pkg::ST_CH_LSB+:3]            = lock_ch_q;
      status_word[bml_pkg::ST_LOCK_BIT]             = locked_q;
      status_word[bml_pkg::ST_SEL_BIT]              = sel_smp_q;
      status_word[bml_pkg::ST_BM_BIT]               = bm_smp_q;
      status_word[bml_pkg::ST_INTERRUPT_ENABLE_STRAP_BIT]            = irq_en_q;
      status_word[bml_pkg::ST_RUN_BIT]              = run_q;
      mask_d  = mask_q;
      rdata_d = rdata_q;
      if (psel && penable && pwrite && (paddr == bml_pkg::REG_CTRL))
      begin
         mask_d = pwdata[3:0];
      end
      if (psel && !penable)
      begin
         rdata_d = 32'h0000_0000;
         if (!pwrite)
         begin
            if (paddr == bml_pkg::REG_CTRL)
            begin
               rdata_d = {28'h0000000, mask_q};
            end
            else if (paddr == bml_pkg::REG_STATUS)
            begin
               rdata_d = status_word;
            end
            else if (paddr == bml_pkg::REG_COUNT)
            begin
               rdata_d = {7'h00, in_cnt_q, 7'h00, wr_cnt_q};
            end
            else if (paddr == bml_pkg::REG_VECTOR)
            begin
               rdata_d = vec_q;
            end
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mask_q  <= bml_pkg::CTRL_MASK_RST;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         mask_q  <= mask_d;
         rdata_q <= rdata_d;
      end
   end
   //------------------------------------------------------------------
   // assertions
   //------------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_pin_input_reset: assert property ((state_q == bml_pkg::S_RESET_WAIT)
      |-> !boot_strap_select_oe)
      else $error("strap select driven before sampling");
   a_eprom_entry: assert property ((state_q == bml_pkg::S_RESET_WAIT)
      && (cnt_q == 8'h00) && !sel_sync
      |=> (state_q == bml_pkg::S_CS_WAIT) && (mode_q == bml_pkg::M_EPROM))
      else $error("low strap did not select eprom boot");
   a_cs_drive_delay: assert property ($rose(state_q == bml_pkg::S_CS_WAIT)
      |-> !boot_strap_select_oe [*8] ##1 boot_strap_select_oe && !boot_strap_select_o)
      else $error("chip select not driven after delay");
   a_slave_idle: assert property ((mode_q == bml_pkg::M_SLAVE)
      |-> !eprom_rd_req && !boot_strap_select_oe)
      else $error("slave boot drove the eprom");
   a_word_limit: assert property (mem_wr_en
      |-> (wr_cnt_q < bml_pkg::BOOT_WORDS) && (in_cnt_q <= bml_pkg::BOOT_WORDS))
      else $error("more than a block of boot words");
   a_boot_vector: assert property (mem_fire && (wr_cnt_q == bml_pkg::LAST_WORD)
      |=> core_start && core_run && (core_start_vector == 32'h0000_0000) && boot_dma_done)
      else $error("load end did not start at zero");
   a_link_locked: assert property ((take && locked_q)
      |-> (word_in_channel == lock_ch_q))
      else $error("word taken from a second channel");
   a_irq_gated: assert property ((state_q == bml_pkg::S_IRQ_WAIT) && !irq_en_q
      |=> !core_run)
      else $error("disabled interrupt started execution");
   a_irq1_vector: assert property ((state_q == bml_pkg::S_IRQ_WAIT) && irq_en_q
      && (irq_act == 4'h2) |=> core_start && (core_start_vector == 32'h3800_0000))
      else $error("wrong vector for interrupt line one");
   a_no_early_run: assert property ($rose(core_run)
      |-> $past(state_q) inside {bml_pkg::S_LOAD, bml_pkg::S_IRQ_WAIT})
      else $error("execution started before boot finished");
   c_eprom_boot: cover property (core_start && (mode_q == bml_pkg::M_EPROM));
   c_slave_boot: cover property (core_start && (mode_q == bml_pkg::M_SLAVE));
   c_noboot_start: cover property (core_start && (mode_q == bml_pkg::M_NOBOOT));
   c_fifo_stall: cover property (word_in_valid && acc_ok && !fifo_in_ready);
endmodule

// [tb/bml_eprom_model.sv]
// boot memory model answering word fetches, also host or link word feeder
`timescale 1ns/1ps
module bml_eprom_model
(
   input  wire logic        clk,
   input  wire logic        cs_n,
   input  wire logic        req,
   input  wire logic [7:0]  addr,
   input  wire logic        ready,
   input  wire logic        go,
   input  wire logic [2:0]  src_ch,
   output      logic        valid,
   output      logic [2:0]  ch,
   output      logic [31:0] data
);
   logic [8:0] hcnt = 9'h000;
   wire        busy = go || (req && !cs_n);
   wire [7:0]  idx  = go ? hcnt[7:0] : addr;
   assign ch = go ? src_ch : 3'h0;
   initial valid = 1'b0;
   initial data = 32'h0;
   always @(posedge clk)
   begin
      valid <= busy && !(valid && ready);
      data <= busy ? {24'hA5A5A5, idx} : ~data;
      hcnt <= go ? hcnt + (valid && ready) : 9'h000;
   end
endmodule

// [tb/tb.sv]
// testbench for the boot mode select loader
`timescale 1ns/1ps
module tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, vec, rd, wd, md;
   logic pready, pslverr, sel_o, sel_oe, serr, strap = 1'b0, bm = 1'b0, ie = 1'b0;
   logic [3:0] irq_n = 4'hF;
   logic req, wv, wr, we, wrdy = 1'b1, done, start, run, go = 1'b0;
   logic [7:0] ra, wa;
   logic [2:0] wch, sch = 3'h0;
   int error_cnt = 0, total_checks = 0, n = 0;
   wire pin = sel_oe ? sel_o : strap;
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) wrdy <= ~wrdy;
   bml_boot_mode_select_loader dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .boot_strap_select_i(pin),
      .boot_strap_select_o(sel_o), .boot_strap_select_oe(sel_oe), .boot_mode_strap(bm),
      .interrupt_enable_strap(ie), .external_interrupt_lines_n(irq_n), .eprom_rd_req(req),
      .eprom_rd_addr(ra), .word_in_valid(wv), .word_in_ready(wr), .word_in_channel(wch),
      .word_in_data(wd), .mem_wr_en(we), .mem_wr_ready(wrdy), .mem_wr_addr(wa),
      .mem_wr_data(md), .boot_dma_done(done), .core_start(start), .core_run(run),
      .core_start_vector(vec));
   bml_eprom_model eprom (.clk(pclk), .cs_n(pin), .req(req), .addr(ra), .ready(wr),
      .go(go), .src_ch(sch), .valid(wv), .ch(wch), .data(wd));
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge pclk)
      if (we === 1'b1 && wrdy === 1'b1)
      begin
         chk("wr_addr", {24'h0, wa}, n);
         chk("wr_data", md, {24'hA5A5A5, n[7:0]});
         n++;
      end
   task boot(input logic s, input logic b, input logic e);
      @(posedge pclk);
      presetn <= 1'b0;
      strap <= s;
      bm <= b;
      ie <= e;
      irq_n <= 4'hF;
      n = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   task wait_start(input int lim);
      int i;
      for (i = 0; i < lim && start !== 1'b1; i++)
      begin
         @(posedge pclk);
         #1;
      end
      if (start !== 1'b1)
      begin
         error_cnt++;
         print_verdict();
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (int k = 0; k < 16; k++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      chk("pready", pready, 1);
      if (pready !== 1'b1)
         print_verdict();
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
   endtask
   task t_eprom;
      boot(1'b0, 1'b0, 1'b0);
      repeat (10) @(posedge pclk);
      #1 chk("oe_early", sel_oe, 0);
      repeat (20) @(posedge pclk);
      #1 chk("cs_low", {sel_oe, sel_o, req}, 3'h5);
      wait_start(5000);
      chk("words", n, 256);
      chk("vector", vec, 32'h0);
      chk("done", done, 1);
      chk("cs_high", {sel_o, req}, 2'h2);
      chk("cs_oe", sel_oe, 1);
      chk("run", run, 1);
      $display("test eprom done");
   endtask
   task t_slave(input logic [2:0] c);
      boot(1'b1, 1'b0, 1'b0);
      sch <= c;
      go <= 1'b1;
      wait_start(5000);
      go <= 1'b0;
      chk("s_words", n, 256);
      chk("s_vec", vec, 32'h0);
      chk("s_done", done, 1);
      chk("s_run", run, 1);
      chk("s_oe", sel_oe, 0);
      apb(1'b0, 12'h008, 32'h0);
      chk("count", rd, 32'h01000100);
      $display("test slave done");
   endtask
   task t_noboot(input logic e);
      boot(1'b1, 1'b1, e);
      repeat (40) @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl", rd, 32'h0000000F);
      apb(1'b0, 12'hFF0, 32'h0);
      chk("slverr", serr, 1);
      chk("run_idle", run, 0);
      if (e)
      begin
         apb(1'b1, 12'h000, 32'h0000000D);
         apb(1'b0, 12'h000, 32'h0);
         chk("ctrl_wr", rd, 32'h0000000D);
         irq_n <= 4'b1101;
         repeat (10) @(posedge pclk);
         #1 chk("masked", run, 0);
         apb(1'b1, 12'h000, 32'h0000000F);
         wait_start(200);
         chk("irq_vec", vec, 32'h38000000);
      end
      else
      begin
         irq_n <= 4'b1001;
         repeat (60) @(posedge pclk);
         #1 chk("no_en", run, 0);
      end
      chk("oe", sel_oe, 0);
      $display("test noboot done");
   endtask
   initial
   begin
      t_eprom();
      t_slave(3'h1);
      t_slave(3'h6);
      t_noboot(1'b1);
      t_noboot(1'b0);
      print_verdict();
   end
endmodule
